// ===== design/can_route_pkg.sv
package can_route_pkg;

    // apb register map (byte addresses, one aligned word each)
    localparam int          ADDR_W           = 12;
    localparam logic [11:0] ADDR_DEST_LOW    = 12'h000;
    localparam logic [11:0] ADDR_DEST_MID    = 12'h004;
    localparam logic [11:0] ADDR_ACCEPT_EN   = 12'h008;
    localparam logic [11:0] ADDR_ROUTE_STAT  = 12'h00c;

    // register widths and reset values
    localparam int          REG_W            = 16;
    localparam logic [15:0] DEST_LOW_RST     = 16'h0000;
    localparam logic [15:0] DEST_MID_RST     = 16'h0000;
    localparam logic [15:0] ACCEPT_EN_RST    = 16'hffff;

    // destination selector coding
    localparam int          SEL_W            = 4;
    localparam int          NUM_FILTERS      = 8;
    localparam int          FILT_IDX_W       = 4;
    localparam int          NUM_BUFS         = 15;
    localparam logic [3:0]  SEL_FIFO         = 4'hf;

    // route status register fields
    localparam int          STAT_SEL_LSB     = 0;
    localparam int          STAT_FIFO_BIT    = 4;
    localparam int          STAT_CNT_LSB     = 8;
    localparam int          STAT_CNT_W       = 8;

endpackage : can_route_pkg

// ===== design/dest_sel_mux.sv
`timescale 1ns/1ps
`default_nettype none

module dest_sel_mux
    import can_route_pkg::*;
(
    // selector registers
    input  wire logic [REG_W-1:0] dest_low,
    input  wire logic [REG_W-1:0] dest_mid,
    // lookup
    input  wire logic [2:0]       filter_idx,
    output logic      [SEL_W-1:0] dest_sel
);

    logic [SEL_W-1:0] sel_table [NUM_FILTERS];

    // filters 0..3 in the low register, 4..7 in the mid register,
    // lowest filter number in the lowest nibble
    genvar i;
    generate
        for (i = 0; i < NUM_FILTERS / 2; i++) begin : g_nib
            assign sel_table[i]   = dest_low[i*SEL_W +: SEL_W]; // RULE1
            assign sel_table[i+4] = dest_mid[i*SEL_W +: SEL_W]; // RULE2 RULE3
        end
    endgenerate

    assign dest_sel = sel_table[filter_idx];

endmodule : dest_sel_mux

`default_nettype wire

// ===== design/dest_decode.sv
`timescale 1ns/1ps
`default_nettype none

module dest_decode
    import can_route_pkg::*;
(
    // selector in
    input  wire logic [SEL_W-1:0]    dest_sel,
    // one-hot destination out
    output logic      [NUM_BUFS-1:0] buf_hit,
    output logic                     fifo_hit
);

    genvar b;
    generate
        for (b = 0; b < NUM_BUFS; b++) begin : g_buf
            assign buf_hit[b] = (dest_sel == SEL_W'(b)); // RULE5
        end
    endgenerate

    assign fifo_hit = (dest_sel == SEL_FIFO); // RULE4

endmodule : dest_decode

`default_nettype wire

// ===== design/can_filter_buffer_routing.sv
// What this block does
// [RULE1] low register holds selectors of filters 0-3
// [RULE2] mid register holds selectors of filters 4-7
// [RULE3] filter 4 selector in mid bits 3:0
// [RULE4] all-ones selector routes message to FIFO
// [RULE5] selector 0-14 routes to that buffer
// [RULE6] disabled filter accepts nothing
// [RULE7] enabled hit on filters 0-7 raises exactly one write-select
`timescale 1ns/1ps
`default_nettype none

module can_filter_buffer_routing
    import can_route_pkg::*;
(
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // apb slave
    input  wire logic [ADDR_W-1:0]     paddr,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // filter hit from the matching logic
    input  wire logic                  hit_valid,
    input  wire logic [FILT_IDX_W-1:0] hit_index,
    // write-select toward buffers and fifo
    output logic                       route_valid,
    output logic      [NUM_BUFS-1:0]   buf_wr_sel,
    output logic                       fifo_wr_sel,
    output logic      [FILT_IDX_W-1:0] route_filter
);

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    logic [REG_W-1:0]      dest_low_r;
    logic [REG_W-1:0]      dest_mid_r;
    logic [REG_W-1:0]      accept_en_r;
    logic [SEL_W-1:0]      last_sel_r;
    logic                  last_fifo_r;
    logic [STAT_CNT_W-1:0] route_cnt_r;
    logic [31:0]           prdata_r;

    wire setup_phase = psel && !penable;
    wire access      = psel && penable;
    wire hit_low     = (paddr == ADDR_DEST_LOW);
    wire hit_mid     = (paddr == ADDR_DEST_MID);
    wire hit_en      = (paddr == ADDR_ACCEPT_EN);
    wire hit_stat    = (paddr == ADDR_ROUTE_STAT);
    wire mapped      = hit_low || hit_mid || hit_en || hit_stat;
    wire wr_access   = access && pwrite;
    wire wr_low      = wr_access && hit_low;
    wire wr_mid      = wr_access && hit_mid;
    wire wr_en       = wr_access && hit_en;

    // status is read-only; a write to it is flagged as an error
    assign pready  = 1'b1;
    assign pslverr = access && (!mapped || (pwrite && hit_stat));
    assign prdata  = prdata_r;

    // byte-lane merge; only the low two lanes hold bits
    function automatic logic [REG_W-1:0] lane_merge(
        input logic [REG_W-1:0] old_val,
        input logic [31:0]      wdata,
        input logic [3:0]       strb
    );
        logic [REG_W-1:0] v;
        v = old_val;
        if (strb[0]) begin
            v[7:0] = wdata[7:0];
        end
        if (strb[1]) begin
            v[15:8] = wdata[15:8];
        end
        return v;
    endfunction : lane_merge

    wire [REG_W-1:0] dest_low_nxt  = lane_merge(dest_low_r, pwdata, pstrb);
    wire [REG_W-1:0] dest_mid_nxt  = lane_merge(dest_mid_r, pwdata, pstrb);
    wire [REG_W-1:0] accept_en_nxt = lane_merge(accept_en_r, pwdata, pstrb);

    wire [REG_W-1:0] status_word =
        {route_cnt_r, 3'b000, last_fifo_r, last_sel_r};

    wire [REG_W-1:0] rd_mux =
        hit_low  ? dest_low_r  :
        hit_mid  ? dest_mid_r  :
        hit_en   ? accept_en_r :
        hit_stat ? status_word : 16'h0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dest_low_r <= DEST_LOW_RST;
        end else if (wr_low) begin
            dest_low_r <= dest_low_nxt; // RULE1
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dest_mid_r <= DEST_MID_RST;
        end else if (wr_mid) begin
            dest_mid_r <= dest_mid_nxt; // RULE2
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            accept_en_r <= ACCEPT_EN_RST;
        end else if (wr_en) begin
            accept_en_r <= accept_en_nxt;
        end
    end

    // read data is captured in the setup cycle so it leaves a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (setup_phase && !pwrite) begin
            prdata_r <= {16'h0000, rd_mux};
        end
    end

    // ------------------------------------------------------------------
    // routing
    // ------------------------------------------------------------------
    logic [SEL_W-1:0]    cur_sel;
    logic [NUM_BUFS-1:0] buf_hit;
    logic                fifo_hit;

    // filters 8..15 are routed elsewhere, never by this block
    wire in_range   = (hit_index < FILT_IDX_W'(NUM_FILTERS));
    wire filt_on    = accept_en_r[hit_index];
    wire accept     = hit_valid && in_range && filt_on; // RULE6

    dest_sel_mux u_sel_mux (
        .dest_low   (dest_low_r),
        .dest_mid   (dest_mid_r),
        .filter_idx (hit_index[2:0]),
        .dest_sel   (cur_sel)
    );

    dest_decode u_decode (
        .dest_sel (cur_sel),
        .buf_hit  (buf_hit),
        .fifo_hit (fifo_hit)
    );

    logic                  route_valid_r;
    logic [NUM_BUFS-1:0]   buf_wr_sel_r;
    logic                  fifo_wr_sel_r;
    logic [FILT_IDX_W-1:0] route_filter_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            route_valid_r <= 1'b0;
            buf_wr_sel_r  <= '0;
            fifo_wr_sel_r <= 1'b0;
        end else begin
            route_valid_r <= accept;                          // RULE7
            buf_wr_sel_r  <= accept ? buf_hit : '0;           // RULE5
            fifo_wr_sel_r <= accept && fifo_hit;              // RULE4
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            route_filter_r <= '0;
            last_sel_r     <= '0;
            last_fifo_r    <= 1'b0;
            route_cnt_r    <= '0;
        end else if (accept) begin
            route_filter_r <= hit_index;
            last_sel_r     <= cur_sel;
            last_fifo_r    <= fifo_hit;
            route_cnt_r    <= route_cnt_r + 8'h01;
        end
    end

    assign route_valid  = route_valid_r;
    assign buf_wr_sel   = buf_wr_sel_r;
    assign fifo_wr_sel  = fifo_wr_sel_r;
    assign route_filter = route_filter_r;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_hit(int f);
        hit_valid && hit_index == FILT_IDX_W'(f) && accept_en_r[f];
    endsequence

    sequence s_full_wr(logic [11:0] a);
        psel && penable && pwrite && paddr == a && pstrb[1:0] == 2'b11;
    endsequence

    // a full write, two quiet cycles on that address, then a hit
    sequence s_wr_then_hit(logic [11:0] a, int f);
        s_full_wr(a) ##1 (!(wr_access && paddr == a)) [*2]
        ##1 s_hit(f);
    endsequence

    // filter 3 takes the top nibble of the low register
    AST_LOW_TOP_NIBBLE: assert property ( // RULE1
        s_hit(3) ##0 dest_low_r[15:12] != SEL_FIFO
        |=> buf_wr_sel == (15'h0001 << $past(dest_low_r[15:12])))
        else $error("filter 3 not routed by low register top nibble");

    // written data, not the old register, steers filter 0 afterwards
    AST_LOW_WRITE_ROUTE: assert property ( // RULE1
        s_wr_then_hit(ADDR_DEST_LOW, 0)
        |=> route_valid &&
            buf_wr_sel == (15'h0001 << $past(pwdata[3:0], 4)) &&
            fifo_wr_sel == ($past(pwdata[3:0], 4) == SEL_FIFO))
        else $error("filter 0 route ignores written low register");

    // written data in mid bits 3:0 steers filter 4 afterwards
    AST_MID_WRITE_ROUTE: assert property ( // RULE3
        s_wr_then_hit(ADDR_DEST_MID, 4)
        |=> route_valid &&
            buf_wr_sel == (15'h0001 << $past(pwdata[3:0], 4)) &&
            fifo_wr_sel == ($past(pwdata[3:0], 4) == SEL_FIFO))
        else $error("filter 4 route ignores written mid register");

    // filter 7 takes the top nibble of the mid register
    AST_MID_TOP_NIBBLE: assert property ( // RULE2
        s_hit(7) ##0 dest_mid_r[15:12] != SEL_FIFO
        |=> buf_wr_sel == (15'h0001 << $past(dest_mid_r[15:12])))
        else $error("filter 7 not routed by mid register top nibble");

    // filter 4 takes the lowest nibble of the mid register
    AST_FILTER4_LOW_NIBBLE: assert property ( // RULE3
        s_hit(4)
        |=> ((fifo_wr_sel == ($past(dest_mid_r[3:0]) == SEL_FIFO)) &&
             (route_filter == 4'h4)))
        else $error("filter 4 not routed by mid bits 3:0");

    // all-ones selector goes to the fifo only
    AST_FIFO_ONLY: assert property ( // RULE4
        accept && cur_sel == SEL_FIFO
        |=> fifo_wr_sel && buf_wr_sel == 15'h0000)
        else $error("fifo selector did not route to fifo alone");

    // selector 0..14 picks the buffer with that number
    AST_BUF_INDEX: assert property ( // RULE5
        accept && cur_sel != SEL_FIFO
        |=> !fifo_wr_sel && buf_wr_sel == (15'h0001 << $past(cur_sel)))
        else $error("buffer selector routed to wrong destination");

    // a disabled filter produces no write-select at all
    AST_DISABLED_SILENT: assert property ( // RULE6
        hit_valid && !accept_en_r[hit_index]
        |=> !route_valid && !fifo_wr_sel && buf_wr_sel == 15'h0000)
        else $error("disabled filter produced a route");

    // each route raises exactly one destination, for one cycle
    AST_ONE_DEST: assert property ( // RULE7
        route_valid
        |-> $onehot({buf_wr_sel, fifo_wr_sel}))
        else $error("route did not select exactly one destination");

    // an accepted hit always routes on the next edge, counted once
    AST_ROUTE_NEXT: assert property ( // RULE7
        accept |=> route_valid && route_cnt_r == $past(route_cnt_r) + 8'h01)
        else $error("accepted hit not routed on next cycle");

    // write-selects only ever travel with a route
    AST_NO_STRAY: assert property ( // RULE7
        !route_valid |-> !fifo_wr_sel && buf_wr_sel == 15'h0000)
        else $error("write-select raised without a route");

    // filters above 7 belong to another block and never route here
    AST_OUT_OF_RANGE: assert property ( // RULE7
        hit_valid && hit_index >= FILT_IDX_W'(NUM_FILTERS) |=> !route_valid)
        else $error("filter above 7 produced a route");

    // the routed filter number is the one that hit
    AST_ROUTE_FILTER: assert property ( // RULE7
        route_valid |-> route_filter == $past(hit_index))
        else $error("route carries wrong filter number");

    // selector and enable registers move only on a write to their own address
    AST_LOW_HOLD: assert property ( // RULE1
        !wr_low |=> $stable(dest_low_r))
        else $error("low selector register changed without a write");

    AST_MID_HOLD: assert property ( // RULE2
        !wr_mid |=> $stable(dest_mid_r))
        else $error("mid selector register changed without a write");

    AST_EN_HOLD: assert property ( // RULE6
        !wr_en |=> $stable(accept_en_r))
        else $error("accept enable register changed without a write");

endmodule : can_filter_buffer_routing

`default_nettype wire

// ===== testbench/hit_source.sv
`timescale 1ns/1ps
`default_nettype none

module hit_source
    import can_route_pkg::*;
(
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // command from the bench
    input  wire logic                  go,
    input  wire logic [FILT_IDX_W-1:0] idx,
    // toward the routing block
    output logic                       hit_valid,
    output logic      [FILT_IDX_W-1:0] hit_index
);
    // index scrambles between hits so a stale value cannot pass as a hit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hit_valid <= 1'b0;
            hit_index <= '0;
        end else begin
            hit_valid <= go;
            hit_index <= go ? idx : ~hit_index;
        end
    end
endmodule : hit_source

`default_nettype wire

// ===== testbench/can_filter_buffer_routing_tb.sv
`timescale 1ns/1ps
`default_nettype none

module can_filter_buffer_routing_tb
    import can_route_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb, idx, hit_index, route_filter;
    logic go, hit_valid, route_valid, fifo_wr_sel, err;
    logic [NUM_BUFS-1:0] buf_wr_sel;
    int failures, comparisons;

    can_filter_buffer_routing uut (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hit_valid(hit_valid), .hit_index(hit_index),
        .route_valid(route_valid), .buf_wr_sel(buf_wr_sel),
        .fifo_wr_sel(fifo_wr_sel), .route_filter(route_filter));
    hit_source far (.pclk(pclk), .presetn(presetn), .go(go), .idx(idx),
        .hit_valid(hit_valid), .hit_index(hit_index));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task tally_and_finish;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            $display("unexpected %s: expected %h seen %h", nm, e, g);
            failures++;
        end
    endtask : chk

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 50) begin
                failures++;
                tally_and_finish;
            end
            @(posedge pclk);
        end
        rd  = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // one hit through the far side, outputs judged in the cycle they stand
    task hit(input logic [3:0] n, input logic ok, input logic [3:0] sel);
        logic [NUM_BUFS-1:0] eb;
        logic                ef;
        ef = ok && (sel == SEL_FIFO);
        eb = '0;
        if (ok && !ef) begin
            eb[sel] = 1'b1;
        end
        @(posedge pclk);
        go  <= 1'b1;
        idx <= n;
        @(posedge pclk);
        go <= 1'b0;
        @(posedge pclk);
        #1;
        chk("route_valid", {31'h0, ok}, {31'h0, route_valid});
        chk("buf_wr_sel", {17'h0, eb}, {17'h0, buf_wr_sel});
        chk("fifo_wr_sel", {31'h0, ef}, {31'h0, fifo_wr_sel});
        if (ok) begin
            chk("route_filter", {28'h0, n}, {28'h0, route_filter});
        end
    endtask : hit

    function automatic logic [3:0] nib(logic [15:0] lo, logic [15:0] mi, int n);
        return 4'((n < 4 ? lo : mi) >> (4 * (n % 4)));
    endfunction : nib

    task t_reset;
        apb(1'b0, ADDR_DEST_LOW, 32'h0);
        chk("low", 32'h0, rd);
        chk("low err", 32'h0, {31'h0, err});
        apb(1'b0, ADDR_DEST_MID, 32'h0);
        chk("mid", 32'h0, rd);
        apb(1'b0, ADDR_ACCEPT_EN, 32'h0);
        chk("enable", 32'hffff, rd);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        apb(1'b1, ADDR_ROUTE_STAT, 32'hff);
        chk("stat err", 32'h1, {31'h0, err});
        apb(1'b0, ADDR_ROUTE_STAT, 32'h0);
        chk("stat", 32'h0, rd);
        hit(4'd0, 1'b1, 4'h0);
    endtask : t_reset

    task t_layout;
        apb(1'b1, ADDR_DEST_MID, 32'h5fa3);
        apb(1'b0, ADDR_DEST_MID, 32'h0);
        chk("mid", 32'h5fa3, rd);
        // filter 0 hit follows the low write at once
        apb(1'b1, ADDR_DEST_LOW, 32'h8fe0);
        for (int n = 0; n < 8; n++) begin
            hit(4'(n), 1'b1, nib(16'h8fe0, 16'h5fa3, n));
        end
        // nine routes so far, the last one filter 7 to buffer 5
        apb(1'b0, ADDR_ROUTE_STAT, 32'h0);
        chk("stat", 32'h0905, rd);
    endtask : t_layout

    task t_codes;
        for (int c = 0; c < 16; c++) begin
            apb(1'b1, ADDR_DEST_MID, {28'h0, 4'(c)});
            hit(4'd4, 1'b1, 4'(c));
        end
        // byte lanes: each strobe updates only its own half
        @(posedge pclk);
        pstrb <= 4'h1;
        apb(1'b1, ADDR_DEST_MID, 32'h0000_ab67);
        apb(1'b0, ADDR_DEST_MID, 32'h0);
        chk("mid lane 0", 32'h0067, rd);
        hit(4'd4, 1'b1, 4'h7);
        @(posedge pclk);
        pstrb <= 4'h2;
        apb(1'b1, ADDR_DEST_MID, 32'h0000_3b98);
        apb(1'b0, ADDR_DEST_MID, 32'h0);
        chk("mid lane 1", 32'h3b67, rd);
        pstrb <= 4'hf;
        hit(4'd7, 1'b1, 4'h3);
    endtask : t_codes

    task t_enable;
        apb(1'b1, ADDR_ACCEPT_EN, 32'hfffb);
        hit(4'd2, 1'b0, 4'h0);
        hit(4'd3, 1'b1, 4'h8);
        apb(1'b1, ADDR_ACCEPT_EN, 32'hffff);
        hit(4'd2, 1'b1, 4'hf);
        hit(4'd9, 1'b0, 4'h0);
    endtask : t_enable

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'hf;
        go = 1'b0;
        idx = '0;
        failures = 0;
        comparisons = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_layout;
        t_codes;
        t_enable;
        tally_and_finish;
    end
endmodule : can_filter_buffer_routing_tb

`default_nettype wire
